// *** hw/psu_unit.sv ***
// How it works
// - the program counter is 13 bits and its low byte reads and writes as a file register.
// - the upper five counter bits are hidden; a holding register keeps software's value for them.
// - a low-byte write loads the upper counter bits from the holding register; a call or a jump loads only bit 11 from it, and clears bit 12.
// - an eight-entry, 13-bit return stack exists whose pointer software cannot see or change.
// - a call and an acknowledged interrupt push the counter plus one onto the stack.
// - a return op (PSU_OP_RET) pops the counter from the stack.
// - push and pop leave the holding register untouched.
// - the stack wraps circularly with no overflow or underflow indication.
// - call and jump carry an 11-bit target inside a 2K-word page.
// - call and jump take the page from bit 3 of the holding register.
// - calls and interrupts save all 13 counter bits so returns come back to the right page.
// - bit 4 of the holding register plays no part in call and jump targets; a low-byte write loads it into counter bit 12.
// - the indirect data port has no storage; accesses to it go to the pointed location.
// - an indirect read of the port through itself returns zero.
// - an indirect write of the port through itself changes no storage.
// - the indirect address is the bank bit joined to 8 pointer bits; only the 8 bits are used.
`timescale 1ns/100ps
`default_nettype none
`include "psu_regs.svh"
module psu_unit (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire psu_pkg::psu_flow_req_type I_FLOW,
    input wire psu_pkg::psu_file_req_type I_FILE,
    input wire logic [7:0] I_MEM_RDATA,
    output psu_pkg::psu_file_req_type O_MEM,
    output logic [7:0] O_RDATA,
    output logic [12:0] O_PC
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [12:0] pc_ff;
    logic [12:0] nxt_pc;
    logic [4:0] pc_upper_holding_ff;
    logic [4:0] nxt_holding;
    logic [7:0] file_select_pointer_ff;
    logic [7:0] nxt_fsp;
    logic [2:0] stack_ptr_ff;
    logic [2:0] nxt_ptr;
    logic [12:0] stack_mem [0:`PSU_STACK_DEPTH-1];
    psu_pkg::psu_file_req_type mem_ff;
    psu_pkg::psu_file_req_type nxt_mem;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rd_local_ff;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire logic [7:0] eff_addr;
    wire logic is_indirect;
    wire logic ind_self;
    wire logic [7:0] tgt_addr;
    wire logic hit_pcl;
    wire logic hit_hold;
    wire logic hit_fsp;
    wire logic hit_local;
    wire logic [2:0] ptr_dec;
    wire logic [12:0] stack_top;
    wire logic [12:0] pc_inc;
    wire logic [12:0] pc_branch;
    wire logic [12:0] pc_lowwr;
    wire logic do_push;
    wire logic do_pop;
    wire logic low_write;

    assign is_indirect = (I_FILE.addr == `PSU_ADDR_INDIRECT)
                       || (I_FILE.addr == `PSU_ADDR_INDIRECT_BANK1);
    // bank bit unused: the 8 pointer bits are the whole address
    assign eff_addr = file_select_pointer_ff;
    assign ind_self = is_indirect && ((eff_addr == `PSU_ADDR_INDIRECT)
                    || (eff_addr == `PSU_ADDR_INDIRECT_BANK1));
    // the port itself holds nothing; it stands for the pointed address
    assign tgt_addr = is_indirect ? eff_addr : I_FILE.addr;
    assign hit_pcl = !ind_self && ((tgt_addr == `PSU_ADDR_PC_LOW)
                   || (tgt_addr == `PSU_ADDR_PC_LOW_BANK1));
    assign hit_hold = !ind_self && ((tgt_addr == `PSU_ADDR_HOLDING)
                    || (tgt_addr == `PSU_ADDR_HOLDING_BANK1));
    assign hit_fsp = !ind_self && ((tgt_addr == `PSU_ADDR_FSP)
                   || (tgt_addr == `PSU_ADDR_FSP_BANK1));
    assign hit_local = hit_pcl || hit_hold || hit_fsp || ind_self;

    // ----------------------------------------
    // program counter
    // ----------------------------------------
    assign ptr_dec = stack_ptr_ff - `PSU_PTR_ONE;
    assign stack_top = stack_mem[ptr_dec];
    assign pc_inc = pc_ff + `PSU_PC_ONE;
    // bit 4 of the holding register is dropped; page from bit 3
    assign pc_branch = {1'b0, pc_upper_holding_ff[`PSU_PAGE_BIT], I_FLOW.target};
    // the full holding value goes up on a low-byte write
    assign pc_lowwr = {pc_upper_holding_ff, I_FILE.wdata};
    assign low_write = I_FILE.wr && hit_pcl;
    assign do_push = (I_FLOW.op == psu_pkg::PSU_OP_CALL)
                   || (I_FLOW.op == psu_pkg::PSU_OP_IRQ);
    assign do_pop = (I_FLOW.op == psu_pkg::PSU_OP_RET);

    always_comb begin
        nxt_pc = pc_ff;
        unique case (I_FLOW.op)
            psu_pkg::PSU_OP_STEP: nxt_pc = pc_inc;
            psu_pkg::PSU_OP_JUMP: nxt_pc = pc_branch;
            psu_pkg::PSU_OP_CALL: nxt_pc = pc_branch;
            psu_pkg::PSU_OP_RET: nxt_pc = stack_top;
            psu_pkg::PSU_OP_IRQ: nxt_pc = `PSU_INT_VECTOR;
            psu_pkg::PSU_OP_NONE: nxt_pc = pc_ff;
            psu_pkg::PSU_OP_HOLD: nxt_pc = pc_ff;
            default: nxt_pc = pc_ff;
        endcase
        // a low-byte write overrides the step of the same instruction
        if (low_write) begin
            nxt_pc = pc_lowwr;
        end
    end

    // stack pointer wraps silently
    assign nxt_ptr = do_push ? (stack_ptr_ff + `PSU_PTR_ONE)
                   : (do_pop ? ptr_dec : stack_ptr_ff);
    // push and pop never touch the holding register
    assign nxt_holding = (I_FILE.wr && hit_hold) ? I_FILE.wdata[4:0] : pc_upper_holding_ff;
    assign nxt_fsp = (I_FILE.wr && hit_fsp) ? I_FILE.wdata : file_select_pointer_ff;

    // ----------------------------------------
    // file access
    // ----------------------------------------
    always_comb begin
        nxt_rdata = `PSU_ZERO_BYTE;
        if (hit_pcl) begin
            nxt_rdata = pc_ff[7:0];
        end else if (hit_hold) begin
            nxt_rdata = {3'h0, pc_upper_holding_ff};
        end else if (hit_fsp) begin
            nxt_rdata = file_select_pointer_ff;
        end
    end

    // outside locations go to data memory; self-indirect stores nothing
    assign nxt_mem = '{rd: I_FILE.rd && !hit_local,
                       wr: I_FILE.wr && !hit_local,
                       addr: tgt_addr,
                       wdata: I_FILE.wdata};

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pc_ff <= `PSU_PC_RESET;
            pc_upper_holding_ff <= `PSU_HOLD_RESET;
            file_select_pointer_ff <= `PSU_FSP_RESET;
            stack_ptr_ff <= `PSU_PTR_RESET;
            mem_ff <= '0;
            rdata_ff <= `PSU_ZERO_BYTE;
            rd_local_ff <= 1'b0;
        end else begin
            pc_ff <= nxt_pc;
            pc_upper_holding_ff <= nxt_holding;
            file_select_pointer_ff <= nxt_fsp;
            stack_ptr_ff <= nxt_ptr;
            mem_ff <= nxt_mem;
            rdata_ff <= nxt_rdata;
            rd_local_ff <= I_FILE.rd && hit_local;
        end
    end

    // stack array carries no reset; stale entries are fine since nothing reports them
    always_ff @(posedge I_REF_CLK) begin
        if (do_push) begin
            stack_mem[stack_ptr_ff] <= pc_inc;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign O_PC = pc_ff;
    assign O_MEM = mem_ff;
    // memory answers in the same cycle as the forwarded strobe; local reads are registered
    assign O_RDATA = rd_local_ff ? rdata_ff : I_MEM_RDATA;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_step_adds_one: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FLOW.op == psu_pkg::PSU_OP_STEP && !low_write) |=> (pc_ff == $past(pc_ff) + `PSU_PC_ONE))
        else $error("step did not add one");
    a_branch_page: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FLOW.op == psu_pkg::PSU_OP_JUMP && !low_write)
        |=> (pc_ff[11] == $past(pc_upper_holding_ff[3]) && pc_ff[12] == 1'b0
             && pc_ff[10:0] == $past(I_FLOW.target)))
        else $error("branch page wrong");
    a_call_return: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FLOW.op == psu_pkg::PSU_OP_CALL && !low_write)
        ##1 (I_FLOW.op == psu_pkg::PSU_OP_NONE)
        ##1 (I_FLOW.op == psu_pkg::PSU_OP_RET && !low_write)
        |=> (pc_ff == $past(pc_ff, 3) + `PSU_PC_ONE))
        else $error("return address wrong");
    a_hold_kept: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (do_push || do_pop) && !(I_FILE.wr && hit_hold)
        |=> $stable(pc_upper_holding_ff))
        else $error("holding changed by stack");
    a_low_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        low_write |=> (pc_ff == {$past(pc_upper_holding_ff), $past(I_FILE.wdata)}))
        else $error("low byte write load wrong");
    a_ptr_wrap: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (stack_ptr_ff == `PSU_PTR_MAX && do_push) |=> (stack_ptr_ff == `PSU_PTR_RESET))
        else $error("stack did not wrap");
    a_self_read_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.rd && ind_self) |=> (O_RDATA == `PSU_ZERO_BYTE))
        else $error("self indirect read not zero");
    a_self_write_none: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.wr && ind_self) |=> (!O_MEM.wr && $stable(file_select_pointer_ff)))
        else $error("self indirect write stored");
    a_indirect_addr: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.rd && is_indirect && !hit_local) |=> (O_MEM.rd
        && O_MEM.addr == $past(file_select_pointer_ff)))
        else $error("indirect address wrong");

    // ----------------------------------------
    // checks: stack
    // ----------------------------------------
    // the pointer is hidden from software, so these and a_ptr_wrap are the only watch on it
    a_ptr_push_inc: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        do_push |=> (stack_ptr_ff == $past(stack_ptr_ff) + `PSU_PTR_ONE))
        else $error("push did not advance pointer");
    a_ptr_pop_dec: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        do_pop |=> (stack_ptr_ff == $past(stack_ptr_ff) - `PSU_PTR_ONE))
        else $error("pop did not retreat pointer");
    a_ptr_idle_kept: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (!do_push && !do_pop) |=> $stable(stack_ptr_ff))
        else $error("pointer moved without push or pop");
    // a wrong return address only shows up many instructions later, so catch it at the push
    a_push_value: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        do_push |=> (stack_mem[$past(stack_ptr_ff)] == $past(pc_inc)))
        else $error("pushed value wrong");
    a_ret_restore: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (do_pop && !low_write) |=> (pc_ff == $past(stack_top)))
        else $error("pop did not restore counter");
    a_irq_vector: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FLOW.op == psu_pkg::PSU_OP_IRQ && !low_write) |=> (pc_ff == `PSU_INT_VECTOR))
        else $error("interrupt vector wrong");
    // on a call, bit 4 of the holding value must never leak into the top counter bit
    a_call_page: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FLOW.op == psu_pkg::PSU_OP_CALL && !low_write)
        |=> (pc_ff[12] == 1'b0 && pc_ff[11] == $past(pc_upper_holding_ff[`PSU_PAGE_BIT])
             && pc_ff[10:0] == $past(I_FLOW.target)))
        else $error("call target wrong");

    // ----------------------------------------
    // checks: counter and holding register
    // ----------------------------------------
    a_pc_idle_kept: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        ((I_FLOW.op == psu_pkg::PSU_OP_NONE || I_FLOW.op == psu_pkg::PSU_OP_HOLD)
        && !low_write) |=> $stable(pc_ff))
        else $error("counter moved while idle");
    a_hold_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.wr && hit_hold) |=> (pc_upper_holding_ff == $past(I_FILE.wdata[4:0])))
        else $error("holding write lost");
    a_pc_low_read: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.rd && hit_pcl) |=> (O_RDATA == $past(pc_ff[7:0])))
        else $error("low byte read wrong");
    // the three unused upper bits read as zero so software sees a clean byte
    a_hold_read: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.rd && hit_hold) |=> (O_RDATA == {3'h0, $past(pc_upper_holding_ff)}))
        else $error("holding read wrong");

    // ----------------------------------------
    // checks: file access
    // ----------------------------------------
    // a stray strobe here would corrupt data memory silently
    a_fwd_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.wr && !hit_local) |=> (O_MEM.wr && O_MEM.addr == $past(tgt_addr)
        && O_MEM.wdata == $past(I_FILE.wdata)))
        else $error("forwarded write wrong");
    a_local_no_fwd: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.rd && hit_local) |=> !O_MEM.rd)
        else $error("local read forwarded");
    a_self_write_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.wr && ind_self) |=> $stable(pc_upper_holding_ff))
        else $error("self indirect write changed holding");
    a_bank_ignored: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_FILE.wr && is_indirect && !hit_local)
        |=> (O_MEM.addr == $past(file_select_pointer_ff)))
        else $error("indirect write address wrong");
    a_mem_one_strobe: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        !(O_MEM.rd && O_MEM.wr))
        else $error("both memory strobes high");
endmodule
`default_nettype wire

// *** hw/psu_regs.svh ***
`ifndef PSU_REGS_SVH
`define PSU_REGS_SVH
// ----------------------------------------
// file addresses of the core registers
// ----------------------------------------
`define PSU_ADDR_INDIRECT 8'h00
`define PSU_ADDR_PC_LOW 8'h02
`define PSU_ADDR_FSP 8'h04
`define PSU_ADDR_HOLDING 8'h0A
`define PSU_ADDR_HOLDING_BANK1 8'h8A
`define PSU_ADDR_PC_LOW_BANK1 8'h82
`define PSU_ADDR_INDIRECT_BANK1 8'h80
`define PSU_ADDR_FSP_BANK1 8'h84
// ----------------------------------------
// widths, fields and reset values
// ----------------------------------------
`define PSU_PC_W 13
`define PSU_STACK_DEPTH 8
`define PSU_PTR_W 3
`define PSU_TARGET_W 11
`define PSU_PAGE_BIT 3
`define PSU_PC_RESET 13'h0000
`define PSU_HOLD_RESET 5'h00
`define PSU_FSP_RESET 8'h00
`define PSU_PTR_RESET 3'h0
`define PSU_ZERO_BYTE 8'h00
`define PSU_INT_VECTOR 13'h0004
`define PSU_PC_ONE 13'h0001
`define PSU_PTR_ONE 3'h1
`define PSU_PTR_MAX 3'h7
`endif

// *** hw/psu_pkg.sv ***
`default_nettype none
package psu_pkg;
    // flow command issued by the decoder for one instruction
    typedef enum logic [6:0] {
        PSU_OP_NONE = 7'h01,
        PSU_OP_STEP = 7'h02,
        PSU_OP_JUMP = 7'h04,
        PSU_OP_CALL = 7'h08,
        PSU_OP_RET = 7'h10,
        PSU_OP_IRQ = 7'h20,
        PSU_OP_HOLD = 7'h40
    } psu_flow_type;

    typedef struct packed {
        psu_flow_type op;
        logic [10:0] target;
    } psu_flow_req_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psu_file_req_type;
endpackage
`default_nettype wire

// *** testbench/psu_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module psu_mem_model (
    input wire logic i_clk,
    input wire psu_pkg::psu_file_req_type i_req,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_ff [256];
    logic [7:0] last_ff = 8'h00;
    // idle bus shows the inverse of the last answer, so a late sample is caught
    assign o_rdata = i_req.rd ? mem_ff[i_req.addr] : ~last_ff;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_ff[i] = 8'(i);
        end
    end
    always @(posedge i_clk) begin
        if (i_req.wr) begin
            mem_ff[i_req.addr] <= i_req.wdata;
        end
        if (i_req.rd) begin
            last_ff <= mem_ff[i_req.addr];
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "psu_regs.svh"
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    psu_pkg::psu_flow_req_type fl = {psu_pkg::PSU_OP_NONE, 11'h000};
    psu_pkg::psu_file_req_type fi = '0;
    psu_pkg::psu_file_req_type mem;
    logic [7:0] mrd;
    logic [7:0] rdata;
    logic [12:0] pc;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    psu_unit uut (.I_REF_CLK(clk), .I_RESETN(rstn), .I_FLOW(fl), .I_FILE(fi),
        .I_MEM_RDATA(mrd), .O_MEM(mem), .O_RDATA(rdata), .O_PC(pc));
    psu_mem_model mm (.i_clk(clk), .i_req(mem), .o_rdata(mrd));
    // ----------------------------------------
    // port tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) fi <= {2'b01, a, d};
        @(posedge clk) fi <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) fi <= {2'b10, a, 8'h00};
        @(posedge clk) fi <= '0;
        #1 chk("read data", {5'h00, e}, {5'h00, rdata});
    endtask
    task automatic mchk(input logic [1:0] e, input logic [7:0] a);
        chk("mem strobes", {11'h000, e}, {11'h000, mem.rd, mem.wr});
        chk("mem addr", {5'h00, a}, {5'h00, mem.addr});
    endtask
    task automatic op(input psu_pkg::psu_flow_type o, input logic [10:0] t,
        input logic [12:0] e);
        @(posedge clk) fl <= {o, t};
        @(posedge clk) fl <= {psu_pkg::PSU_OP_NONE, 11'h000};
        #1 chk("pc", e, pc);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_pc;
        chk("pc reset", 13'h0000, pc);
        wr(`PSU_ADDR_HOLDING, 8'h00);
        wr(`PSU_ADDR_PC_LOW, 8'hFF);
        op(psu_pkg::PSU_OP_STEP, 11'h000, 13'h0100);
        wr(`PSU_ADDR_HOLDING, 8'h05);
        wr(`PSU_ADDR_PC_LOW_BANK1, 8'h55);
        chk("pc low write", 13'h0555, pc);
        rd(`PSU_ADDR_PC_LOW, 8'h55);
        $display("test pc done");
    endtask
    task automatic t_call;
        // bit 4 set on purpose: it must not reach the counter
        wr(`PSU_ADDR_HOLDING, 8'h18);
        op(psu_pkg::PSU_OP_CALL, 11'h100, 13'h0900);
        op(psu_pkg::PSU_OP_RET, 11'h000, 13'h0556);
        rd(`PSU_ADDR_HOLDING_BANK1, 8'h18);
        op(psu_pkg::PSU_OP_IRQ, 11'h000, `PSU_INT_VECTOR);
        op(psu_pkg::PSU_OP_RET, 11'h000, 13'h0557);
        op(psu_pkg::PSU_OP_JUMP, 11'h7FF, 13'h0FFF);
        op(psu_pkg::PSU_OP_HOLD, 11'h000, 13'h0FFF);
        $display("test call done");
    endtask
    task automatic t_wrap;
        logic [12:0] v [1:9];
        wr(`PSU_ADDR_HOLDING, 8'h00);
        wr(`PSU_ADDR_PC_LOW, 8'h00);
        for (int i = 1; i <= 9; i++) begin
            v[i] = (i == 1) ? 13'h0001 : 13'((i - 1) * 16 + 1);
            op(psu_pkg::PSU_OP_CALL, 11'(i * 16), 13'(i * 16));
        end
        // the ninth push has replaced the first, so the last pop sees it again
        for (int j = 9; j >= 1; j--) begin
            op(psu_pkg::PSU_OP_RET, 11'h000, v[(j == 1) ? 9 : j]);
        end
        $display("test wrap done");
    endtask
    task automatic t_ind;
        wr(`PSU_ADDR_FSP, 8'h20);
        wr(`PSU_ADDR_INDIRECT, 8'hA5);
        mchk(2'b01, 8'h20);
        chk("mem wdata", 13'h00A5, {5'h00, mem.wdata});
        rd(`PSU_ADDR_INDIRECT_BANK1, 8'hA5);
        rd(`PSU_ADDR_FSP_BANK1, 8'h20);
        wr(`PSU_ADDR_FSP, 8'h00);
        rd(`PSU_ADDR_INDIRECT, 8'h00);
        wr(`PSU_ADDR_INDIRECT, 8'h3C);
        chk("self write strobes", 13'h0000, {11'h000, mem.rd, mem.wr});
        wr(`PSU_ADDR_FSP, 8'h80);
        wr(`PSU_ADDR_INDIRECT_BANK1, 8'h3C);
        chk("alias write strobes", 13'h0000, {11'h000, mem.rd, mem.wr});
        rd(`PSU_ADDR_INDIRECT, 8'h00);
        rd(8'h20, 8'hA5);
        $display("test indirect done");
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic stop_test;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the whole sequence needs a little over a hundred cycles; this cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_pc();
        t_call();
        t_wrap();
        t_ind();
        stop_test();
    end
endmodule
`default_nettype wire
